// ==== hw/spd_ctl_end.sv ====
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module spd_ctl_end
  import spd_pkg::*;
#(
  parameter int PAUSE_CYCLES = PAUSE_CYC
) (
  input  logic        REF_CLK,
  input  logic        RST,
  input  logic [7:0]  ADDR,
  input  logic [31:0] WDATA,
  input  logic        WR,
  input  logic        RD,
  output logic [31:0] RDATA,
  spd_if.ctl          BUS
);

  if (PAUSE_CYCLES < 1 || PAUSE_CYCLES > 65535) begin : g_chk
    $error("PAUSE_CYCLES must fit the 16-bit timer");
  end

  typedef enum logic [6:0] {
    S_PAUSE = 7'h01,
    S_PREA  = 7'h02,
    S_REF   = 7'h04,
    S_MRS   = 7'h08,
    S_READY = 7'h10,
    S_PD    = 7'h20,
    S_PDX   = 7'h40
  } spd_ctl_e;

  function automatic logic [15:0] wait_of(input spd_cmd_t op,
                                          input logic [AW-1:0] mr);
    case (op)
      CMD_ACT: wait_of = 16'(RCD_CYC);
      CMD_RD:  wait_of = 16'(spd_bl_len(mr) + spd_cl(mr) + 1);
      CMD_WR:  wait_of = 16'(spd_bl_len(mr) + WR_CYC);
      CMD_PRE: wait_of = 16'(RP_CYC);
      CMD_REF: wait_of = 16'(RC_CYC);
      CMD_MRS: wait_of = 16'(MRS_WAIT_CYC);
      default: wait_of = 16'h0001;
    endcase
  endfunction : wait_of

  ////////////////////////////////////////////////////////////////////////////
  // registers

  spd_ctl_e      state_r;
  spd_ctl_e      state_nxt;
  logic          pd_req_r;
  logic [AW-1:0] mode_r;
  logic          pend_r;
  logic [14:0]   pend_word_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] rdata_r;
  logic          rd_valid_r;
  logic [1:0]    open_r;
  logic          tmr_busy;
  logic          iss;
  logic          capture;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pd_req_r <= 1'b0;
      mode_r   <= MR_RESET;
      wdata_r  <= '0;
    end else if (WR) begin
      if (ADDR == REG_CTRL) begin
        pd_req_r <= WDATA[CTRL_PD_BIT];
      end
      if (ADDR == REG_MODE) begin
        mode_r <= WDATA[AW-1:0];
      end
      if (ADDR == REG_WDATA) begin
        wdata_r <= WDATA[DW-1:0];
      end
    end
  end

  // a command written while one is pending is ignored
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pend_r      <= 1'b0;
      pend_word_r <= '0;
    end else if (WR && ADDR == REG_CMD && !pend_r) begin
      pend_r      <= 1'b1;
      pend_word_r <= WDATA[14:0];
    end else if (iss && state_r == S_READY) begin
      pend_r      <= 1'b0;
    end
  end

  // capture sets even in the cycle software reads the flag
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_valid_r <= 1'b0;
      rdata_r    <= '0;
    end else if (capture) begin
      rd_valid_r <= 1'b1;
      rdata_r    <= BUS.dq;
    end else if (RD && ADDR == REG_RDATA) begin
      rd_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        REG_CTRL:   RDATA <= 32'(pd_req_r);
        REG_MODE:   RDATA <= 32'(mode_r);
        REG_CMD:    RDATA <= 32'(pend_word_r);
        REG_WDATA:  RDATA <= 32'(wdata_r);
        REG_RDATA:  RDATA <= 32'(rdata_r);
        REG_STATUS: RDATA <= 32'({rd_valid_r, state_r == S_PD,
                                  pend_r || tmr_busy,
                                  !(state_r inside {S_PAUSE, S_PREA,
                                                    S_REF, S_MRS}),
                                  open_r});
        default:    RDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  logic          armed_r;
  logic [3:0]    ref_cnt_r;
  spd_cmd_t      iss_cmd;
  logic [AW-1:0] iss_addr;
  logic          tmr_load;
  logic [15:0]   tmr_val;

  always_comb begin
    state_nxt = state_r;
    iss       = 1'b0;
    iss_cmd   = CMD_NOP;
    iss_addr  = '0;
    tmr_load  = 1'b0;
    tmr_val   = 16'h0001;
    case (state_r)
      S_PAUSE: begin
        if (!armed_r) begin
          tmr_load = 1'b1;
          tmr_val  = 16'(PAUSE_CYCLES);
        end else if (!tmr_busy) begin
          state_nxt = S_PREA;
        end
      end
      S_PREA: begin
        if (!tmr_busy) begin
          iss       = 1'b1;
          iss_cmd   = CMD_PRE;
          iss_addr  = AW'(1) << A_AP;
          state_nxt = S_REF;
        end
      end
      S_REF: begin
        if (!tmr_busy && ref_cnt_r == 4'(INIT_REFRESH_N)) begin
          state_nxt = S_MRS;
        end else if (!tmr_busy) begin
          iss     = 1'b1;
          iss_cmd = CMD_REF;
        end
      end
      S_MRS: begin
        if (!tmr_busy) begin
          iss       = 1'b1;
          iss_cmd   = CMD_MRS;
          iss_addr  = mode_r;
          state_nxt = S_READY;
        end
      end
      S_READY: begin
        if (!tmr_busy && pend_r) begin
          iss      = 1'b1;
          iss_cmd  = pend_word_r[CMD_OP_LSB +: 3];
          iss_addr = pend_word_r[AW-1:0];
        end else if (!tmr_busy && pd_req_r && open_r == 2'b00) begin
          state_nxt = S_PD;
        end
      end
      S_PD: begin
        if (!pd_req_r) begin
          state_nxt = S_PDX;
          tmr_load  = 1'b1;
          tmr_val   = 16'(PD_EXIT_CYC);
        end
      end
      S_PDX: begin
        if (!tmr_busy) begin
          state_nxt = S_READY;
        end
      end
      default: begin
        state_nxt = S_PAUSE;
      end
    endcase
    if (iss) begin
      tmr_load = 1'b1;
      tmr_val  = wait_of(iss_cmd, mode_r);
    end
  end

  spd_timer #(.W(16)) u_tmr (
    .clk   (REF_CLK),
    .rst   (RST),
    .load  (tmr_load),
    .value (tmr_val),
    .busy  (tmr_busy),
    .fire  ()
  );

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r   <= S_PAUSE;
      armed_r   <= 1'b0;
      ref_cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      armed_r <= 1'b1;
      if (iss && iss_cmd == CMD_REF && state_r == S_REF) begin
        ref_cnt_r <= ref_cnt_r + 4'h1;
      end
    end
  end

  // bank bookkeeping, so power-down waits for closed banks
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      open_r <= 2'b00;
    end else if (iss && iss_cmd == CMD_ACT) begin
      open_r[iss_addr[A_BS]] <= 1'b1;
    end else if (iss && iss_cmd == CMD_PRE) begin
      open_r <= iss_addr[A_AP] ? 2'b00 : (open_r & ~(2'b01 << iss_addr[A_BS]));
    end else if (iss && (iss_cmd == CMD_RD || iss_cmd == CMD_WR)
                 && iss_addr[A_AP]) begin
      open_r[iss_addr[A_BS]] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins; every command and data word is registered

  logic [3:0] wr_left_r;
  logic [2:0] cap_r;
  spd_cmd_t   cmd_r;
  logic       cs_n_r;
  logic       cke_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] dq_o_r;
  logic          dq_oe_r;

  assign capture = (cap_r == 3'h1);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cke_r     <= 1'b1;
      cmd_r     <= CMD_NOP;
      cs_n_r    <= 1'b1;
      addr_r    <= '0;
      dq_o_r    <= '0;
      dq_oe_r   <= 1'b0;
      wr_left_r <= 4'h0;
      cap_r     <= 3'h0;
    end else begin
      cke_r  <= (state_nxt != S_PD);
      cmd_r  <= iss ? iss_cmd : CMD_NOP;
      cs_n_r <= !iss;
      addr_r <= iss_addr;
      // one write word repeated over the burst: no data buffer
      if (iss && iss_cmd == CMD_WR) begin
        dq_o_r    <= wdata_r;
        dq_oe_r   <= 1'b1;
        wr_left_r <= spd_bl_len(mode_r) - 4'h1;
      end else if (wr_left_r != 4'h0) begin
        wr_left_r <= wr_left_r - 4'h1;
      end else begin
        dq_oe_r   <= 1'b0;
      end
      if (iss && iss_cmd == CMD_RD) begin
        cap_r <= spd_cl(mode_r) + 3'h1;
      end else if (cap_r != 3'h0) begin
        cap_r <= cap_r - 3'h1;
      end
    end
  end

  assign BUS.cke       = cke_r;
  assign BUS.cs_n      = cs_n_r;
  assign BUS.ras_n     = cmd_r[2];
  assign BUS.cas_n     = cmd_r[1];
  assign BUS.we_n      = cmd_r[0];
  assign BUS.addr      = addr_r;
  assign BUS.dqm       = 1'b0;
  assign BUS.dq_ctl    = dq_o_r;
  assign BUS.dq_ctl_oe = dq_oe_r;

endmodule : spd_ctl_end

// ==== hw/spd_pkg.sv ====
package spd_pkg;

  localparam int DW     = 16;
  localparam int AW     = 12;
  localparam int MAX_CL = 3;

  // address pin roles
  localparam int A_AP = 10;  // auto_precharge_flag_bit / all_bank_bit
  localparam int A_BS = 11;  // bank_select_bit

  // mode word fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT     = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [AW-1:0] MR_RESET = 12'h032;

  // {ras_n, cas_n, we_n}
  typedef logic [2:0] spd_cmd_t;
  localparam spd_cmd_t CMD_MRS = 3'h0;
  localparam spd_cmd_t CMD_REF = 3'h1;
  localparam spd_cmd_t CMD_PRE = 3'h2;
  localparam spd_cmd_t CMD_ACT = 3'h3;
  localparam spd_cmd_t CMD_WR  = 3'h4;
  localparam spd_cmd_t CMD_RD  = 3'h5;
  localparam spd_cmd_t CMD_BST = 3'h6;
  localparam spd_cmd_t CMD_NOP = 3'h7;

  // timing
  localparam int CLK_PS     = 4000;
  localparam int T_RC_NS    = 54;
  localparam int T_RP_NS    = 16;
  localparam int T_RCD_NS   = 16;
  localparam int T_WR_NS    = 6;
  localparam int T_PAUSE_US = 200;
  localparam int RC_CYC     = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC     = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RCD_CYC    = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WR_CYC     = (T_WR_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PAUSE_CYC  = T_PAUSE_US * 1000 * 1000 / CLK_PS;
  localparam int INIT_REFRESH_N = 8;
  localparam int MRS_WAIT_CYC   = 2;
  localparam int PD_EXIT_CYC    = 1;
  localparam logic [1:0] AP_RD_DLY     = 2'h1;
  localparam logic [1:0] AP_WR_DLY     = 2'h1;
  localparam logic [1:0] AP_WR_DLY_CL3 = 2'h2;

  // controller registers
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MODE   = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_PD_BIT   = 0;
  localparam int CMD_OP_LSB    = 12;
  localparam int ST_OPEN_LSB   = 0;
  localparam int ST_INIT_DONE  = 2;
  localparam int ST_BUSY       = 3;
  localparam int ST_PD         = 4;
  localparam int ST_RD_VALID   = 5;

  function automatic logic [3:0] spd_bl_len(input logic [AW-1:0] mr);
    case (mr[MR_BL_LSB +: 3])
      3'h0:    spd_bl_len = 4'h1;
      3'h1:    spd_bl_len = 4'h2;
      3'h2:    spd_bl_len = 4'h4;
      default: spd_bl_len = 4'h8;  // full page served as eight words
    endcase
  endfunction : spd_bl_len

  function automatic logic [2:0] spd_cl(input logic [AW-1:0] mr);
    case (mr[MR_CL_LSB +: 3])
      3'h1:    spd_cl = 3'h1;
      3'h2:    spd_cl = 3'h2;
      default: spd_cl = 3'h3;
    endcase
  endfunction : spd_cl

endpackage : spd_pkg

// ==== hw/spd_if.sv ====
`timescale 1ns/1ps
interface spd_if;
  import spd_pkg::*;
  logic          cke;
  logic          cs_n;
  logic          ras_n;
  logic          cas_n;
  logic          we_n;
  logic          dqm;
  logic [AW-1:0] addr;
  logic [DW-1:0] dq_ctl;
  logic          dq_ctl_oe;
  logic [DW-1:0] dq_mem;
  logic          dq_mem_oe;
  logic [DW-1:0] dq;

  // resolved data lines; an undriven bus reads as zero
  assign dq = dq_mem_oe ? dq_mem : (dq_ctl_oe ? dq_ctl : '0);

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, dqm, addr,
               output dq_ctl, dq_ctl_oe, input dq);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, dqm, addr,
               output dq_mem, dq_mem_oe, input dq);
endinterface : spd_if

// ==== hw/spd_timer.sv ====
`timescale 1ns/1ps
module spd_timer #(
  parameter int W = 16
) (
  input  logic         clk,
  input  logic         rst,
  input  logic         load,
  input  logic [W-1:0] value,
  output logic         busy,
  output logic         fire
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);
  assign fire = (cnt_r == W'(1));
endmodule : spd_timer

// ==== hw/spd_sdram_end.sv ====
`timescale 1ns/1ps
module spd_sdram_end
  import spd_pkg::*;
#(
  parameter int COLW = 4
) (
  input  logic       REF_CLK,
  input  logic       RST,
  spd_if.mem         BUS,
  output logic [1:0] BANK_OPEN,
  output logic       POWER_DOWN,
  output logic       PRECHARGE_EVT
);

  localparam int DEPTH = 2 << COLW;

  if (COLW < 3 || COLW > A_AP) begin : g_chk
    $error("COLW must lie between 3 and the flag bit position");
  end

  // column of beat idx inside the burst-aligned group
  function automatic logic [COLW-1:0] col_at(input logic [COLW-1:0] start,
                                             input logic [3:0]      idx,
                                             input logic [3:0]      len,
                                             input logic            il);
    logic [COLW-1:0] m;
    logic [COLW-1:0] off;
    m      = COLW'(len - 4'h1);
    off    = COLW'(idx);
    col_at = il ? (start ^ (off & m))
                : ((start & ~m) | ((start + off) & m));
  endfunction : col_at

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic            cke_prev_r;
  logic            pd_r;
  logic [AW-1:0]   mr_r;
  logic [1:0]      open_r;
  logic            live;
  spd_cmd_t        cmd;
  logic            is_rd;
  logic            is_wr;
  logic            is_pre;
  logic            is_bst;
  logic            is_act;
  logic            is_mrs;
  logic [1:0]      pre_mask;
  logic            new_acc;

  // a command counts only if clock enable was high one edge earlier
  assign live   = cke_prev_r && !pd_r;
  assign cmd    = {BUS.ras_n, BUS.cas_n, BUS.we_n};
  assign is_rd  = live && !BUS.cs_n && (cmd == CMD_RD);
  assign is_wr  = live && !BUS.cs_n && (cmd == CMD_WR);
  assign is_pre = live && !BUS.cs_n && (cmd == CMD_PRE);
  assign is_bst = live && !BUS.cs_n && (cmd == CMD_BST);
  assign is_act = live && !BUS.cs_n && (cmd == CMD_ACT);
  assign is_mrs = live && !BUS.cs_n && (cmd == CMD_MRS);

  always_comb begin
    if (!is_pre) begin
      pre_mask = 2'b00;
    end else if (BUS.addr[A_AP]) begin
      pre_mask = 2'b11;
    end else begin
      pre_mask = BUS.addr[A_BS] ? 2'b10 : 2'b01;
    end
  end

  // accesses to a closed bank are dropped
  assign new_acc = (is_rd || is_wr) && open_r[BUS.addr[A_BS]];

  ////////////////////////////////////////////////////////////////////////////
  // burst engine

  logic            on_r;
  logic            wr_r;
  logic            ap_r;
  logic            bank_r;
  logic            il_r;
  logic [COLW-1:0] start_r;
  logic [3:0]      idx_r;
  logic [3:0]      len_r;
  logic            stop_now;
  logic            beat_v;
  logic            beat_wr;
  logic            beat_ap;
  logic            beat_bank;
  logic            beat_last;
  logic [3:0]      beat_len;
  logic [3:0]      beat_idx;
  logic [COLW-1:0] beat_col;
  logic [COLW:0]   beat_addr;

  assign stop_now  = on_r && (is_bst || pre_mask[bank_r]);
  // clock enable low without power-down freezes the burst
  assign beat_v    = new_acc || (on_r && cke_prev_r && !stop_now);
  assign beat_wr   = new_acc ? is_wr : wr_r;
  assign beat_ap   = new_acc ? BUS.addr[A_AP] : ap_r;
  assign beat_bank = new_acc ? BUS.addr[A_BS] : bank_r;
  assign beat_len  = new_acc ? spd_bl_len(mr_r) : len_r;
  assign beat_idx  = new_acc ? 4'h0 : idx_r;
  assign beat_col  = col_at(new_acc ? BUS.addr[COLW-1:0] : start_r,
                            beat_idx, beat_len,
                            new_acc ? mr_r[MR_BT] : il_r);
  assign beat_last = (beat_idx == beat_len - 4'h1);
  assign beat_addr = {beat_bank, beat_col};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      on_r    <= 1'b0;
      wr_r    <= 1'b0;
      ap_r    <= 1'b0;
      bank_r  <= 1'b0;
      il_r    <= 1'b0;
      start_r <= '0;
      idx_r   <= 4'h0;
      len_r   <= 4'h1;
    end else if (new_acc) begin
      on_r    <= (spd_bl_len(mr_r) != 4'h1);
      wr_r    <= is_wr;
      ap_r    <= BUS.addr[A_AP];
      bank_r  <= BUS.addr[A_BS];
      il_r    <= mr_r[MR_BT];
      start_r <= BUS.addr[COLW-1:0];
      idx_r   <= 4'h1;
      len_r   <= spd_bl_len(mr_r);
    end else if (stop_now) begin
      on_r    <= 1'b0;
    end else if (beat_v) begin
      idx_r   <= idx_r + 4'h1;
      on_r    <= !beat_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage; row address is not kept, one page per bank

  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge REF_CLK) begin
    // the stop cycle has no beat, so its word and the rest are lost
    if (beat_v && beat_wr && !BUS.dqm) begin
      mem_r[beat_addr] <= BUS.dq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline, tapped by latency

  logic [MAX_CL-1:0] rv_r;
  logic [DW-1:0]     rd_r [MAX_CL];
  logic              flush;
  logic [1:0]        tap;

  // a write cutting a read takes the lines at once
  assign flush = new_acc && is_wr;

  always_ff @(posedge REF_CLK) begin
    if (RST || flush) begin
      rv_r[0] <= 1'b0;
    end else begin
      rv_r[0] <= beat_v && !beat_wr;
    end
    rd_r[0] <= mem_r[beat_addr];
  end

  for (genvar g = 1; g < MAX_CL; g++) begin : g_pipe
    always_ff @(posedge REF_CLK) begin
      if (RST || flush) begin
        rv_r[g] <= 1'b0;
      end else begin
        rv_r[g] <= rv_r[g-1];
      end
      rd_r[g] <= rd_r[g-1];
    end
  end

  assign tap           = 2'(spd_cl(mr_r) - 3'h1);
  assign BUS.dq_mem    = rd_r[tap];
  assign BUS.dq_mem_oe = rv_r[tap];

  ////////////////////////////////////////////////////////////////////////////
  // auto precharge

  logic       ap_load;
  logic [1:0] ap_dly;
  logic       ap_fire;
  logic       ap_bank_r;

  // same start cycle for all three read latencies: right after the last fetch
  assign ap_load = beat_v && beat_last && beat_ap;
  assign ap_dly  = !beat_wr ? AP_RD_DLY :
                   (spd_cl(mr_r) == 3'h3) ? AP_WR_DLY_CL3 :
                   AP_WR_DLY;

  spd_timer #(.W(2)) u_ap_tmr (
    .clk   (REF_CLK),
    .rst   (RST),
    .load  (ap_load),
    .value (ap_dly),
    .busy  (),
    .fire  (ap_fire)
  );

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ap_bank_r <= 1'b0;
    end else if (ap_load) begin
      ap_bank_r <= beat_bank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank state, mode word, power-down

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      open_r <= 2'b00;
    end else begin
      // closed bank stays closed until a later activate
      open_r <= ((open_r & ~pre_mask)
                 & ~({1'b0, ap_fire} << ap_bank_r))
                | ({1'b0, is_act} << BUS.addr[A_BS]);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PRECHARGE_EVT <= 1'b0;
    end else begin
      PRECHARGE_EVT <= (|(pre_mask & open_r)) || ap_fire;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mr_r <= MR_RESET;
    end else if (is_mrs && open_r == 2'b00 && !on_r) begin
      mr_r <= BUS.addr;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= BUS.cke;
    end
  end

  // no refresh timer exists here; refresh is only ever commanded
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pd_r <= 1'b0;
    end else if (!pd_r && !BUS.cke && open_r == 2'b00 && !on_r) begin
      pd_r <= 1'b1;
    end else if (pd_r && BUS.cke) begin
      pd_r <= 1'b0;
    end
  end

  assign BANK_OPEN  = open_r;
  assign POWER_DOWN = pd_r;

endmodule : spd_sdram_end

// ==== dv/spd_chk_sva.sv ====
`timescale 1ns/1ps
module spd_chk
  import spd_pkg::*;
(
  input logic          REF_CLK,
  input logic          RST,
  input logic          cke,
  input logic          cs_n,
  input logic          ras_n,
  input logic          cas_n,
  input logic          we_n,
  input logic [AW-1:0] addr,
  input logic          dq_mem_oe,
  input logic          dq_ctl_oe,
  input logic [1:0]    BANK_OPEN,
  input logic          POWER_DOWN,
  input logic          PRECHARGE_EVT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // a command counts only if the device listened at that edge
  logic cke_q_r;
  logic go;
  logic pre;
  logic hit;
  always_ff @(posedge REF_CLK) cke_q_r <= cke;
  assign go  = !cs_n && cke && cke_q_r && !POWER_DOWN;
  assign pre = go && {ras_n, cas_n, we_n} == CMD_PRE;
  assign hit = go && BANK_OPEN[addr[A_BS]] && ras_n && !cas_n;
  ////////////////////////////////////////
  pd_entry_a: assert property (
    !cke && cke_q_r && !POWER_DOWN && BANK_OPEN == 2'h0 |=> POWER_DOWN)
    else $error("power-down not entered");
  pd_exit_a: assert property (POWER_DOWN && cke |=> !POWER_DOWN)
    else $error("power-down not left one clock later");
  pd_hold_a: assert property (POWER_DOWN && !cke |=> POWER_DOWN)
    else $error("power-down dropped early");
  pd_nop_a: assert property (POWER_DOWN |-> cs_n || we_n && cas_n)
    else $error("command while powered down");
  pd_closed_a: assert property ($fell(cke) |-> BANK_OPEN == 2'h0)
    else $error("clock enable dropped with open bank");
  pre_all_a: assert property (pre && addr[A_AP] |=> BANK_OPEN == 2'h0)
    else $error("precharge all left a bank open");
  pre_bank_a: assert property (
    pre && !addr[A_AP] |=> !BANK_OPEN[$past(addr[A_BS])])
    else $error("addressed bank not closed");
  ap_close_a: assert property (
    hit && addr[A_AP] |-> ##[1:13] PRECHARGE_EVT)
    else $error("auto precharge missing");
  rd_drive_a: assert property (hit && we_n |-> ##[1:3] dq_mem_oe)
    else $error("read data not driven");
  no_clash_a: assert property (!(dq_mem_oe && dq_ctl_oe))
    else $error("both sides drive data");
endmodule : spd_chk

// ==== dv/sdram_precharge_powerdown_ctl_tb_top.sv ====
`timescale 1ns/1ps
module sdram_precharge_powerdown_ctl_tb_top;
  import spd_pkg::*;
  logic        REF_CLK = 1'h0;
  logic        RST     = 1'h1;
  logic [7:0]  ADDR    = 8'h00;
  logic [31:0] WDATA   = 32'h0;
  logic        WR      = 1'h0;
  logic        RD      = 1'h0;
  logic [31:0] RDATA;
  logic [1:0]  BANK_OPEN;
  logic        POWER_DOWN;
  logic        PRECHARGE_EVT;
  logic [31:0] v;
  int          fails     = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  spd_if bus ();
  // short pause keeps the power-up wait inside the run budget
  spd_ctl_end #(.PAUSE_CYCLES(20)) i_spd_ctl_end (.REF_CLK, .RST, .ADDR,
    .WDATA, .WR, .RD, .RDATA, .BUS(bus));
  spd_sdram_end i_spd_sdram_end (.REF_CLK, .RST, .BUS(bus), .BANK_OPEN,
    .POWER_DOWN, .PRECHARGE_EVT);
  spd_chk i_spd_chk (.REF_CLK, .RST, .cke(bus.cke), .cs_n(bus.cs_n),
    .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
    .addr(bus.addr), .dq_mem_oe(bus.dq_mem_oe), .dq_ctl_oe(bus.dq_ctl_oe),
    .BANK_OPEN, .POWER_DOWN, .PRECHARGE_EVT);
  always #2 REF_CLK = ~REF_CLK;
  ////////////////////////////////////////
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'h1;
    @(posedge REF_CLK);
    WR    <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge REF_CLK);
    ADDR <= a;
    RD   <= 1'h1;
    @(posedge REF_CLK);
    RD   <= 1'h0;
    @(negedge REF_CLK);
    v = RDATA;
  endtask : rd
  task automatic poll(input int b, input logic x);
    for (int k = 0; k < 400; k++) begin
      rd(REG_STATUS);
      if (v[b] === x) return;
    end
    fails++;
  endtask : poll
  // trailing NOP waits out the timer, so the bank state has settled
  task automatic cmd(input spd_cmd_t o, input logic [11:0] a);
    wr(REG_CMD, {17'h0, o, a});
    wr(REG_CMD, {17'h0, CMD_NOP, 12'h000});
    poll(ST_BUSY, 1'h0);
    rd(REG_STATUS);
  endtask : cmd
  function automatic logic [11:0] col_a(input logic b, f,
                                        input logic [3:0] c);
    return {b, f, 6'h00, c};
  endfunction : col_a
  initial begin
    logic [2:0] cl;
    logic [1:0] bl;
    logic [3:0] col;
    logic [15:0] d;
    logic b, f, g, s, it;
    void'($urandom(53610));
    repeat (20) @(posedge REF_CLK);
    RST <= 1'h0;
    poll(ST_INIT_DONE, 1'h1);
    chk("open banks", v[1:0], 2'h0);
    rd(8'hFC);
    for (int i = 0; i < 12; i++) begin
      cl  = 3'($urandom_range(3, 1));
      bl  = 2'($urandom);
      col = 4'($urandom);
      d   = 16'($urandom);
      {b, f, g, s, it} = 5'($urandom);
      // the controller paces bursts from its own copy of the mode word
      wr(REG_MODE, {20'h0, 5'h00, cl, it, 1'h0, bl});
      cmd(CMD_MRS, {5'h00, cl, it, 1'h0, bl});
      cmd(CMD_ACT, {b, 11'h000});
      wr(REG_WDATA, {16'h0000, d});
      cmd(CMD_WR, col_a(b, f, col));
      chk("open after write", v[b], !f);
      chk("bank after write", BANK_OPEN[b], !f);
      if (f) cmd(CMD_ACT, {b, 11'h000});
      cmd(CMD_RD, col_a(b, g, col));
      chk("open after read", v[b], !g);
      chk("bank after read", BANK_OPEN[b], !g);
      poll(ST_RD_VALID, 1'h1);
      rd(REG_RDATA);
      chk("read word", v, {16'h0000, d});
      if (!g) begin
        cmd(CMD_BST, 12'h000);
        chk("open after stop", v[b], 1'h1);
        cmd(CMD_PRE, {b ^ s, s, 10'h000});
        chk("open after close", v[1:0], 2'h0);
        chk("banks after close", BANK_OPEN, 2'h0);
      end
      wr(REG_CTRL, 32'h1);
      poll(ST_PD, 1'h1);
      chk("power down", POWER_DOWN, 1'h1);
      wr(REG_CTRL, 32'h0);
      poll(ST_PD, 1'h0);
      chk("power up", POWER_DOWN, 1'h0);
    end
    tally_and_finish();
  end
endmodule : sdram_precharge_powerdown_ctl_tb_top
